// File: pmrf_pkg.sv
// Register offsets, field positions and reset values of the result/flag bank
`default_nettype none
package pmrf_pkg;
    localparam logic [5:0] PMRF_OFS_BUS_VOLTAGE = 6'h05;
    localparam logic [5:0] PMRF_OFS_DIE_TEMP = 6'h06;
    localparam logic [5:0] PMRF_OFS_CURRENT = 6'h07;
    localparam logic [5:0] PMRF_OFS_POWER = 6'h08;
    localparam logic [5:0] PMRF_OFS_ENERGY = 6'h09;
    localparam logic [5:0] PMRF_OFS_CHARGE = 6'h0A;
    localparam logic [5:0] PMRF_OFS_FLAGS = 6'h0B;

    localparam int PMRF_BIT_HOLD_MODE = 15;
    localparam int PMRF_BIT_CNV_ALERT_EN = 14;
    localparam int PMRF_BIT_ON_AVERAGED = 13;
    localparam int PMRF_BIT_POLARITY = 12;
    localparam int PMRF_BIT_ENERGY_OF = 11;
    localparam int PMRF_BIT_CHARGE_OF = 10;
    localparam int PMRF_BIT_MATH_OF = 9;
    localparam int PMRF_BIT_OVER_TEMP = 7;
    localparam int PMRF_BIT_OVER_CUR = 6;
    localparam int PMRF_BIT_UNDER_CUR = 5;
    localparam int PMRF_BIT_BUS_OVER = 4;
    localparam int PMRF_BIT_BUS_UNDER = 3;
    localparam int PMRF_BIT_PWR_OVER = 2;
    localparam int PMRF_BIT_CNV_DONE = 1;
    localparam int PMRF_BIT_TRIM_OK = 0;

    // Index of each limit flag inside the six-bit limit vector
    localparam int PMRF_LIM_PWR_OVER = 0;
    localparam int PMRF_LIM_BUS_UNDER = 1;
    localparam int PMRF_LIM_BUS_OVER = 2;
    localparam int PMRF_LIM_UNDER_CUR = 3;
    localparam int PMRF_LIM_OVER_CUR = 4;
    localparam int PMRF_LIM_OVER_TEMP = 5;

    localparam logic [15:0] PMRF_RST_FLAGS = 16'h0001;
    localparam logic [15:0] PMRF_RST_RESULT16 = 16'h0000;
    localparam logic [11:0] PMRF_RST_TEMP = 12'h000;
    localparam logic [23:0] PMRF_RST_POWER = 24'h000000;
    localparam logic [39:0] PMRF_RST_ACC = 40'h0000000000;
    localparam logic [3:0] PMRF_TEMP_PAD = 4'h0;
    localparam logic [7:0] PMRF_PWR_LIMIT_PAD = 8'h00;
endpackage : pmrf_pkg
`default_nettype wire

// File: pmrf_bank.sv
// Result registers, diagnostic flags and alert pin control of a power monitor
// Operation
// RULE1 - Bus voltage result is 16-bit two's complement, never negative.
// RULE2 - Die temperature in bits 15:4 two's complement; bits 3:0 read zero.
// RULE3 - Current result is 16-bit two's complement.
// RULE4 - Power result is 24-bit unsigned.
// RULE5 - Energy accumulator is 40-bit unsigned, resets to zero.
// RULE6 - Charge accumulator is 40-bit two's complement, resets to zero.
// RULE7 - Transparent mode follows the fault; latched mode holds until read.
// RULE8 - Conversion-ready routing drives alert from conversion-complete flag.
// RULE9 - Alert-on-averaged selects raw or averaged values for comparisons.
// RULE10 - Polarity bit: clear gives active-low, set gives active-high alert.
// RULE11 - Energy overflow flag sets on wrap, clears only on accumulator clear.
// RULE12 - Charge overflow flag sets on wrap, clears only on accumulator clear.
// RULE13 - Arithmetic overflow flag clears on new conversion or accumulator clear.
// RULE14 - Over-temperature flag sets when temperature exceeds its limit.
// RULE15 - Overcurrent flag sets when current exceeds its over-limit.
// RULE16 - Undercurrent flag sets when current falls below its under-limit.
// RULE17 - Bus over-limit flag sets when bus voltage exceeds its over-limit.
// RULE18 - Bus under-limit flag sets when bus voltage falls below under-limit.
// RULE19 - Power over-limit flag sets when power exceeds its limit.
// RULE20 - In latched mode a flag register read clears the limit flags.
// RULE21 - Conversion-complete flag sets at end; latched clears on read or start.
// RULE22 - Trim checksum bit resets to one, drops on error; bit 8 reads zero.
// RULE23 - Result registers update only after the averaging sequence finishes.
// RULE24 - Temperature limit compares directly in the temperature result format.
// RULE25 - Alert active on any limit flag, or conversion flag when routed.
`timescale 1ns/1ps
`default_nettype none
module pmrf_bank
    import pmrf_pkg::*;
#(
    parameter int ENERGY_INC_W = 24,
    parameter int CHARGE_INC_W = 16
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Register port from the serial interface engine
    input wire logic [5:0] i_reg_addr,
    input wire logic i_reg_rd,
    input wire logic i_reg_wr,
    input wire logic [15:0] i_reg_wdata,
    output logic [39:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Raw samples from the converter, one pulse per sample set
    input wire logic i_raw_valid,
    input wire logic [15:0] i_raw_bus,
    input wire logic [11:0] i_raw_temp,
    input wire logic [15:0] i_raw_current,
    input wire logic [23:0] i_raw_power,
    // Completed (averaged) results, one pulse per finished conversion
    input wire logic i_avg_valid,
    input wire logic [15:0] i_avg_bus,
    input wire logic [11:0] i_avg_temp,
    input wire logic [15:0] i_avg_current,
    input wire logic [23:0] i_avg_power,
    // Accumulator increments
    input wire logic i_acc_valid,
    input wire logic [ENERGY_INC_W-1:0] i_energy_inc,
    input wire logic [CHARGE_INC_W-1:0] i_charge_inc,
    // Events from the measurement engine and configuration logic
    input wire logic i_math_overflow,
    input wire logic i_conv_start,
    input wire logic i_accumulator_clear,
    input wire logic i_trim_error,
    // Programmed thresholds
    input wire logic [15:0] i_cur_over_limit,
    input wire logic [15:0] i_cur_under_limit,
    input wire logic [14:0] i_bus_over_limit,
    input wire logic [14:0] i_bus_under_limit,
    input wire logic [11:0] i_temp_limit,
    input wire logic [15:0] i_power_limit,
    // Open-drain alert pin
    output logic o_alert_out,
    output logic o_alert_oe
);

    logic [15:0] bus_voltage_result_reg;
    logic [11:0] die_temperature_result_reg;
    logic [15:0] current_result_reg;
    logic [23:0] power_result_reg;
    logic [39:0] energy_accumulator_reg;
    logic [39:0] charge_accumulator_reg;

    logic alert_hold_mode_reg;
    logic conversion_ready_alert_enable_reg;
    logic alert_on_averaged_reg;
    logic alert_polarity_select_reg;
    logic energy_overflow_flag_reg;
    logic charge_overflow_flag_reg;
    logic arithmetic_overflow_flag_reg;
    logic conversion_complete_flag_reg;
    logic trim_checksum_ok_reg;
    logic [5:0] limit_flags_reg;
    logic [39:0] rdata_reg;
    logic rvalid_reg;
    logic alert_oe_reg;

    logic flags_read;
    logic cmp_valid;
    logic [15:0] cmp_bus;
    logic [11:0] cmp_temp;
    logic [15:0] cmp_current;
    logic [23:0] cmp_power;
    logic [5:0] limit_hit;
    logic [40:0] energy_sum;
    logic [39:0] charge_inc_ext;
    logic [39:0] charge_sum;
    logic charge_wrap;
    logic [15:0] flags_word;
    logic alert_active;
    logic ctrl_write;

    assign flags_read = i_reg_rd && (i_reg_addr == PMRF_OFS_FLAGS);

    // Comparison source: every raw sample or only the finished average
    always_comb begin
        if (alert_on_averaged_reg) begin // RULE9
            cmp_valid = i_avg_valid;
            cmp_bus = i_avg_bus;
            cmp_temp = i_avg_temp;
            cmp_current = i_avg_current;
            cmp_power = i_avg_power;
        end else begin
            cmp_valid = i_raw_valid;
            cmp_bus = i_raw_bus;
            cmp_temp = i_raw_temp;
            cmp_current = i_raw_current;
            cmp_power = i_raw_power;
        end
    end

    // Limits and results share one format except power, whose limit is scaled by 256
    always_comb begin
        limit_hit[PMRF_LIM_OVER_TEMP] =
            $signed(cmp_temp) > $signed(i_temp_limit); // RULE14 RULE24
        limit_hit[PMRF_LIM_OVER_CUR] =
            $signed(cmp_current) > $signed(i_cur_over_limit); // RULE15
        limit_hit[PMRF_LIM_UNDER_CUR] =
            $signed(cmp_current) < $signed(i_cur_under_limit); // RULE16
        limit_hit[PMRF_LIM_BUS_OVER] =
            cmp_bus > {1'b0, i_bus_over_limit}; // RULE17
        limit_hit[PMRF_LIM_BUS_UNDER] =
            cmp_bus < {1'b0, i_bus_under_limit}; // RULE18
        // Power limit counts in steps of 256 result LSBs
        limit_hit[PMRF_LIM_PWR_OVER] =
            cmp_power > {i_power_limit, PMRF_PWR_LIMIT_PAD}; // RULE19
    end

    // Results change only when a full averaging run has finished
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            bus_voltage_result_reg <= PMRF_RST_RESULT16;
        end else if (i_avg_valid) begin // RULE23
            // A negative bus reading can only be noise around zero
            bus_voltage_result_reg <= i_avg_bus[15] ? PMRF_RST_RESULT16
                                                    : i_avg_bus; // RULE1
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            die_temperature_result_reg <= PMRF_RST_TEMP;
        end else if (i_avg_valid) begin // RULE23
            die_temperature_result_reg <= i_avg_temp; // RULE2
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            current_result_reg <= PMRF_RST_RESULT16;
        end else if (i_avg_valid) begin // RULE23
            current_result_reg <= i_avg_current; // RULE3
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            power_result_reg <= PMRF_RST_POWER;
        end else if (i_avg_valid) begin // RULE23
            power_result_reg <= i_avg_power; // RULE4
        end
    end

    assign energy_sum = {1'b0, energy_accumulator_reg}
                      + {{(41 - ENERGY_INC_W){1'b0}}, i_energy_inc};
    // Signed cast extends the sign and stays legal at full width
    assign charge_inc_ext = 40'($signed(i_charge_inc));
    assign charge_sum = charge_accumulator_reg + charge_inc_ext;
    assign charge_wrap = (charge_accumulator_reg[39] == charge_inc_ext[39])
                      && (charge_sum[39] != charge_accumulator_reg[39]);

    // Accumulators wrap; the overflow flags record that they did
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_accumulator_clear) begin
            energy_accumulator_reg <= PMRF_RST_ACC; // RULE5
            charge_accumulator_reg <= PMRF_RST_ACC; // RULE6
        end else if (i_acc_valid) begin
            energy_accumulator_reg <= energy_sum[39:0]; // RULE5
            charge_accumulator_reg <= charge_sum; // RULE6
        end
    end

    // Overflow flags: a wrap in the clearing cycle still sets the flag
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            energy_overflow_flag_reg <= 1'b0;
            charge_overflow_flag_reg <= 1'b0;
        end else begin
            if (i_acc_valid && energy_sum[40]) begin
                energy_overflow_flag_reg <= 1'b1; // RULE11
            end else if (i_accumulator_clear) begin
                energy_overflow_flag_reg <= 1'b0; // RULE11
            end
            if (i_acc_valid && charge_wrap) begin
                charge_overflow_flag_reg <= 1'b1; // RULE12
            end else if (i_accumulator_clear) begin
                charge_overflow_flag_reg <= 1'b0; // RULE12
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            arithmetic_overflow_flag_reg <= 1'b0;
        end else if (i_math_overflow) begin
            arithmetic_overflow_flag_reg <= 1'b1; // RULE13
        end else if (i_conv_start || i_accumulator_clear) begin
            arithmetic_overflow_flag_reg <= 1'b0; // RULE13
        end
    end

    // Limit flags: transparent follows each comparison, latched accumulates
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            limit_flags_reg <= 6'h00;
        end else if (alert_hold_mode_reg) begin
            if (cmp_valid) begin
                // New hits win over the read clear
                limit_flags_reg <= (flags_read ? 6'h00 : limit_flags_reg)
                                 | limit_hit; // RULE7 RULE20
            end else if (flags_read) begin
                limit_flags_reg <= 6'h00; // RULE20
            end
        end else if (cmp_valid) begin
            limit_flags_reg <= limit_hit; // RULE7
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            conversion_complete_flag_reg <= 1'b0;
        end else if (i_avg_valid) begin
            conversion_complete_flag_reg <= 1'b1; // RULE21
        end else if (i_conv_start
                     || (alert_hold_mode_reg && flags_read)) begin
            conversion_complete_flag_reg <= 1'b0; // RULE21
        end
    end

    // Once the trim check fails the bit stays low until reset
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            trim_checksum_ok_reg <= PMRF_RST_FLAGS[PMRF_BIT_TRIM_OK]; // RULE22
        end else if (i_trim_error) begin
            trim_checksum_ok_reg <= 1'b0; // RULE22
        end
    end

    // Only the four behaviour controls take writes
    assign ctrl_write = i_reg_wr && (i_reg_addr == PMRF_OFS_FLAGS);

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            alert_hold_mode_reg <= PMRF_RST_FLAGS[PMRF_BIT_HOLD_MODE];
        end else if (ctrl_write) begin
            alert_hold_mode_reg <= i_reg_wdata[PMRF_BIT_HOLD_MODE];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            conversion_ready_alert_enable_reg <=
                PMRF_RST_FLAGS[PMRF_BIT_CNV_ALERT_EN];
        end else if (ctrl_write) begin
            conversion_ready_alert_enable_reg <=
                i_reg_wdata[PMRF_BIT_CNV_ALERT_EN];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            alert_on_averaged_reg <= PMRF_RST_FLAGS[PMRF_BIT_ON_AVERAGED];
        end else if (ctrl_write) begin
            alert_on_averaged_reg <= i_reg_wdata[PMRF_BIT_ON_AVERAGED];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            alert_polarity_select_reg <= PMRF_RST_FLAGS[PMRF_BIT_POLARITY];
        end else if (ctrl_write) begin
            alert_polarity_select_reg <= i_reg_wdata[PMRF_BIT_POLARITY];
        end
    end

    always_comb begin
        flags_word = 16'h0000; // RULE22
        flags_word[PMRF_BIT_HOLD_MODE] = alert_hold_mode_reg;
        flags_word[PMRF_BIT_CNV_ALERT_EN] = conversion_ready_alert_enable_reg;
        flags_word[PMRF_BIT_ON_AVERAGED] = alert_on_averaged_reg;
        flags_word[PMRF_BIT_POLARITY] = alert_polarity_select_reg;
        flags_word[PMRF_BIT_ENERGY_OF] = energy_overflow_flag_reg;
        flags_word[PMRF_BIT_CHARGE_OF] = charge_overflow_flag_reg;
        flags_word[PMRF_BIT_MATH_OF] = arithmetic_overflow_flag_reg;
        flags_word[PMRF_BIT_OVER_TEMP] = limit_flags_reg[PMRF_LIM_OVER_TEMP];
        flags_word[PMRF_BIT_OVER_CUR] = limit_flags_reg[PMRF_LIM_OVER_CUR];
        flags_word[PMRF_BIT_UNDER_CUR] = limit_flags_reg[PMRF_LIM_UNDER_CUR];
        flags_word[PMRF_BIT_BUS_OVER] = limit_flags_reg[PMRF_LIM_BUS_OVER];
        flags_word[PMRF_BIT_BUS_UNDER] = limit_flags_reg[PMRF_LIM_BUS_UNDER];
        flags_word[PMRF_BIT_PWR_OVER] = limit_flags_reg[PMRF_LIM_PWR_OVER];
        flags_word[PMRF_BIT_CNV_DONE] = conversion_complete_flag_reg;
        flags_word[PMRF_BIT_TRIM_OK] = trim_checksum_ok_reg;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= i_reg_rd;
        end
    end

    // Read data is captured before a read-clear takes effect
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rdata_reg <= PMRF_RST_ACC;
        end else begin
            if (i_reg_rd) begin
                unique case (i_reg_addr)
                    PMRF_OFS_BUS_VOLTAGE: rdata_reg <=
                        {24'h000000, bus_voltage_result_reg}; // RULE1
                    PMRF_OFS_DIE_TEMP: rdata_reg <= {24'h000000,
                        die_temperature_result_reg, PMRF_TEMP_PAD}; // RULE2
                    PMRF_OFS_CURRENT: rdata_reg <=
                        {24'h000000, current_result_reg}; // RULE3
                    PMRF_OFS_POWER: rdata_reg <=
                        {16'h0000, power_result_reg}; // RULE4
                    PMRF_OFS_ENERGY: rdata_reg <= energy_accumulator_reg;
                    PMRF_OFS_CHARGE: rdata_reg <= charge_accumulator_reg;
                    PMRF_OFS_FLAGS: rdata_reg <= {24'h000000, flags_word};
                    default: rdata_reg <= PMRF_RST_ACC;
                endcase
            end
        end
    end

    assign alert_active = (|limit_flags_reg)
                        || (conversion_ready_alert_enable_reg
                            && conversion_complete_flag_reg); // RULE8 RULE25

    // The pin only ever pulls low; active-high means releasing it when active
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            alert_oe_reg <= 1'b0;
        end else begin
            alert_oe_reg <= alert_active ^ alert_polarity_select_reg; // RULE10
        end
    end

    assign o_alert_out = 1'b0;
    assign o_alert_oe = alert_oe_reg;
    assign o_reg_rdata = rdata_reg;
    assign o_reg_rvalid = rvalid_reg;

endmodule : pmrf_bank
`default_nettype wire

// File: pmrf_bank_chk.sv
// Assertions on the result/flag bank register port and alert pin
`timescale 1ns/1ps
`default_nettype none
module pmrf_bank_chk
    import pmrf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [5:0] i_reg_addr,
    input wire logic i_reg_rd,
    input wire logic [39:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic o_alert_out
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_rd(logic [5:0] a);
        i_reg_rd && i_reg_addr == a ##1 o_reg_rvalid;
    endsequence
    // Reset edge loads zero, so the edge after it is not a hold violation
    property p_hold;
        !o_reg_rvalid && !$past(i_sys_rst) |-> $stable(o_reg_rdata);
    endproperty
    a_rd_answers: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered in the next cycle");
    a_rvalid_caused: assert property (o_reg_rvalid |-> $past(i_reg_rd))
        else $error("read data valid without a read");
    a_rdata_holds: assert property (p_hold)
        else $error("read data moved without a read");
    a_bus_nonneg: assert property (s_rd(PMRF_OFS_BUS_VOLTAGE)
        |-> o_reg_rdata[39:15] == 25'h0000000)
        else $error("bus voltage result negative or too wide");
    a_temp_pad: assert property (s_rd(PMRF_OFS_DIE_TEMP)
        |-> o_reg_rdata[39:16] == 24'h000000
        && o_reg_rdata[3:0] == PMRF_TEMP_PAD)
        else $error("temperature padding bits not zero");
    a_cur_width: assert property (s_rd(PMRF_OFS_CURRENT)
        |-> o_reg_rdata[39:16] == 24'h000000)
        else $error("current result wider than 16 bits");
    a_pwr_width: assert property (s_rd(PMRF_OFS_POWER)
        |-> o_reg_rdata[39:24] == 16'h0000)
        else $error("power result wider than 24 bits");
    a_flag_rsvd: assert property (s_rd(PMRF_OFS_FLAGS)
        |-> o_reg_rdata[39:16] == 24'h000000 && !o_reg_rdata[8])
        else $error("flag register reserved bits set");
    a_alert_data: assert property (o_alert_out == 1'b0)
        else $error("open-drain alert data not low");
endmodule : pmrf_bank_chk
`default_nettype wire

// File: pmrf_host.sv
// Register-port host model issuing reads and writes to the bank
`timescale 1ns/1ps
`default_nettype none
module pmrf_host (
    input wire logic i_clk,
    input wire logic i_rvalid,
    input wire logic [39:0] i_rdata,
    output logic [5:0] o_addr,
    output logic o_rd,
    output logic o_wr,
    output logic [15:0] o_wdata
);
    initial begin
        {o_addr, o_rd, o_wr, o_wdata} = 24'h000000;
    end
    // Idle address and data are inverted so nothing leans on stale values
    task automatic rd(input logic [5:0] a, output logic [39:0] d,
                      output bit ok);
        @(posedge i_clk) #1;
        {o_addr, o_rd} = {a, 1'b1};
        @(posedge i_clk) #1;
        {o_addr, o_rd} = {~a, 1'b0};
        ok = i_rvalid;
        d = i_rdata;
    endtask : rd
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge i_clk) #1;
        {o_addr, o_wdata, o_wr} = {a, d, 1'b1};
        @(posedge i_clk) #1;
        {o_addr, o_wdata, o_wr} = {~a, ~d, 1'b0};
    endtask : wr
endmodule : pmrf_host
`default_nettype wire

// File: pmrf_bank_bench.sv
// Self-checking bench for the result/flag bank and its register host
`timescale 1ns/1ps
`default_nettype none
module pmrf_bank_bench
    import pmrf_pkg::*;
;
    logic clk, rst, rd, wr, rvalid, rawv, avgv, accv, out, oe;
    logic [5:0] addr;
    logic [15:0] wdata, b, c, co, cu, pl;
    logic [39:0] rdata, einc, cinc;
    logic [11:0] t, tl;
    logic [23:0] p;
    logic [14:0] bo, bu;
    logic [3:0] ev;
    int fail_count = 0;
    int cmp_count = 0;
    // Full-width increments let both accumulators wrap in two steps
    pmrf_bank #(.ENERGY_INC_W(40), .CHARGE_INC_W(40)) pmrf_bank_i (
        .i_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_rd(rd),
        .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .i_raw_valid(rawv), .i_raw_bus(b),
        .i_raw_temp(t), .i_raw_current(c), .i_raw_power(p),
        .i_avg_valid(avgv), .i_avg_bus(b), .i_avg_temp(t),
        .i_avg_current(c), .i_avg_power(p), .i_acc_valid(accv),
        .i_energy_inc(einc), .i_charge_inc(cinc), .i_math_overflow(ev[3]),
        .i_conv_start(ev[2]), .i_accumulator_clear(ev[1]),
        .i_trim_error(ev[0]), .i_cur_over_limit(co),
        .i_cur_under_limit(cu), .i_bus_over_limit(bo),
        .i_bus_under_limit(bu), .i_temp_limit(tl), .i_power_limit(pl),
        .o_alert_out(out), .o_alert_oe(oe));
    pmrf_host pmrf_host_i (.i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata),
        .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));
    task automatic final_report;
        $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic rdc(input logic [5:0] a, input logic [39:0] e);
        logic [39:0] d;
        bit ok;
        pmrf_host_i.rd(a, d, ok);
        if (!ok) begin
            fail_count++;
            $display("[ERR] %0t read got no answer", $time);
            final_report();
        end
        chk(d, e);
    endtask : rdc
    // Ends two cycles after the sample so the alert pin has settled
    task automatic smp(input bit av, input logic [15:0] vb,
                       input logic [11:0] vt, input logic [15:0] vc,
                       input logic [23:0] vp);
        @(posedge clk) #1;
        {b, t, c, p, rawv, avgv} = {vb, vt, vc, vp, !av, av};
        @(posedge clk) #1;
        {rawv, avgv} = 2'h0;
        @(posedge clk) #1;
    endtask : smp
    task automatic trip(input bit av);
        smp(av, 16'h000F, 12'h006, 16'h000F, 24'h000001);
    endtask : trip
    task automatic norm(input bit av);
        smp(av, 16'h0064, 12'h000, 16'h0000, 24'h000000);
    endtask : norm
    task automatic lim(input bit tight);
        {co, cu, bo, bu, tl, pl} = tight ?
            {16'h000A, 16'h0014, 15'h000A, 15'h0014, 12'h005, 16'h0000} :
            {16'h7FFF, 16'h8000, 15'h7FFF, 15'h0000, 12'h7FF, 16'hFFFF};
    endtask : lim
    task automatic pulse(input logic [3:0] m);
        @(posedge clk) #1;
        ev = m;
        @(posedge clk) #1;
        ev = 4'h0;
        @(posedge clk) #1;
    endtask : pulse
    task automatic acc(input logic [39:0] e, input logic [39:0] q);
        @(posedge clk) #1;
        {accv, einc, cinc} = {1'b1, e, q};
        @(posedge clk) #1;
        accv = 1'b0;
    endtask : acc
    task automatic t_reset;
        for (int a = 4; a <= 12; a++)
            rdc(6'(a), (a == 11) ? 40'h1 : 40'h0);
    endtask : t_reset
    task automatic t_results;
        smp(1, 16'h1234, 12'hF9C, 16'hFF85, 24'hABCDEF);
        rdc(PMRF_OFS_BUS_VOLTAGE, 40'h1234);
        rdc(PMRF_OFS_DIE_TEMP, 40'hF9C0);
        rdc(PMRF_OFS_CURRENT, 40'hFF85);
        rdc(PMRF_OFS_POWER, 40'hABCDEF);
        rdc(PMRF_OFS_FLAGS, 40'h3);
        smp(1, 16'h8001, 12'h000, 16'h0000, 24'h000000);
        smp(0, 16'h0777, 12'h000, 16'h0000, 24'h000000);
        rdc(PMRF_OFS_BUS_VOLTAGE, 40'h0);
        pulse(4'h4);
        rdc(PMRF_OFS_FLAGS, 40'h1);
    endtask : t_results
    task automatic t_accum;
        acc(40'hFFFFFFFFFF, 40'h7FFFFFFFFF);
        acc(40'h2, 40'h1);
        rdc(PMRF_OFS_ENERGY, 40'h1);
        rdc(PMRF_OFS_CHARGE, 40'h8000000000);
        pulse(4'h8);
        rdc(PMRF_OFS_FLAGS, 40'hE01);
        pulse(4'h4);
        rdc(PMRF_OFS_FLAGS, 40'hC01);
        pulse(4'h8);
        pulse(4'h2);
        rdc(PMRF_OFS_CHARGE, 40'h0);
        rdc(PMRF_OFS_FLAGS, 40'h1);
    endtask : t_accum
    task automatic t_limits;
        lim(1);
        trip(0);
        rdc(PMRF_OFS_FLAGS, 40'hFD);
        chk({39'h0, oe}, 40'h1);
        smp(0, 16'h0019, 12'h005, 16'h0005, 24'h000000);
        rdc(PMRF_OFS_FLAGS, 40'h31);
        lim(0);
        norm(0);
        rdc(PMRF_OFS_FLAGS, 40'h1);
        chk({39'h0, oe}, 40'h0);
    endtask : t_limits
    task automatic t_latched;
        pmrf_host_i.wr(PMRF_OFS_FLAGS, 16'h8000);
        lim(1);
        trip(0);
        lim(0);
        norm(0);
        chk({39'h0, oe}, 40'h1);
        rdc(PMRF_OFS_FLAGS, 40'h80FD);
        @(posedge clk) #1;
        chk({39'h0, oe}, 40'h0);
        rdc(PMRF_OFS_FLAGS, 40'h8001);
        norm(1);
        rdc(PMRF_OFS_FLAGS, 40'h8003);
        rdc(PMRF_OFS_FLAGS, 40'h8001);
        norm(1);
        pulse(4'h4);
        rdc(PMRF_OFS_FLAGS, 40'h8001);
    endtask : t_latched
    task automatic t_pin;
        pmrf_host_i.wr(PMRF_OFS_FLAGS, 16'h4000);
        norm(1);
        chk({39'h0, oe}, 40'h1);
        pulse(4'h4);
        chk({39'h0, oe}, 40'h0);
        pmrf_host_i.wr(PMRF_OFS_FLAGS, 16'h1000);
        norm(1);
        chk({39'h0, oe}, 40'h1);
        lim(1);
        trip(0);
        chk({39'h0, oe}, 40'h0);
        lim(0);
        norm(0);
    endtask : t_pin
    task automatic t_avg_ro;
        pmrf_host_i.wr(PMRF_OFS_FLAGS, 16'h2000);
        lim(1);
        trip(0);
        rdc(PMRF_OFS_FLAGS, 40'h2003);
        trip(1);
        rdc(PMRF_OFS_FLAGS, 40'h20FF);
        lim(0);
        norm(0);
        rdc(PMRF_OFS_FLAGS, 40'h20FF);
        norm(1);
        pmrf_host_i.wr(PMRF_OFS_BUS_VOLTAGE, 16'hFFFF);
        pmrf_host_i.wr(PMRF_OFS_FLAGS, 16'h0FFF);
        rdc(PMRF_OFS_BUS_VOLTAGE, 40'h64);
        rdc(PMRF_OFS_FLAGS, 40'h3);
        pulse(4'h1);
        rdc(PMRF_OFS_FLAGS, 40'h2);
    endtask : t_avg_ro
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {rst, rawv, avgv, accv, ev} = 8'h80;
        {b, t, c, p, einc, cinc} = 148'h0;
        lim(0);
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        t_reset();
        t_results();
        t_accum();
        t_limits();
        t_latched();
        t_pin();
        t_avg_ro();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("[ERR] %0t run did not complete", $time);
        final_report();
    end
endmodule : pmrf_bank_bench
bind pmrf_bank pmrf_bank_chk pmrf_bank_chk_i (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .o_alert_out(o_alert_out));
`default_nettype wire
